// File: rtl/mcu_clock_consts.vh
// constants for the microcontroller clock and reset output block
// assumes a 100 MHz reference clock and the 30 MHz crystal seen as a sampled pin
//
// Functional notes
// - three-bit select picks 30/15/10/4/3/2/1 MHz or the 32.768 kHz clock
// - fast choices divide the crystal; the slow one comes from the low-frequency input
// - control register resets to 06h, giving 1 MHz out
// - sleep with low-frequency enable set outputs the slow clock regardless of select
// - sleep with low-frequency enable clear stops the output clock
// - before stopping, emit 0, 128, 256 or 512 tail cycles per tail field
// - pending interrupt keeps the output clock running whatever mode is commanded
// - sleep and crystal disable wait until the interrupt has been read
// - software reset request gives an internal reset pulse of 50 to 470 us
// - any reset returns the control register to its default
// - active reset is driven on the first general-purpose pin
// - inverted reset is driven on the second general-purpose pin
// - leaving shutdown or power-on holds reset for 5 to 40 ms
`ifndef MCU_CLOCK_CONSTS_VH
`define MCU_CLOCK_CONSTS_VH

// ==========================================
// register map
`define MCO_CTRL_ADDR 7'h0a
`define MCO_CTRL_RESET 8'h06
`define MCO_FREQ_LSB 0
`define MCO_SLOW_EN_BIT 3
`define MCO_TAIL_LSB 4

// ==========================================
// clock select codes and crystal half-periods per output period
`define FREQ_SLOW 3'h7
`define HP_30M 6'h02
`define HP_15M 6'h04
`define HP_10M 6'h06
`define HP_4M 6'h0f
`define HP_3M 6'h14
`define HP_2M 6'h1e
`define HP_1M 6'h3c

// ==========================================
// clock tail lengths
`define TAIL_128 10'h080
`define TAIL_256 10'h100
`define TAIL_512 10'h200

// ==========================================
// timing
`define REF_CLK_MHZ 100
`define SOFT_RST_TIME_US 50
`define GLITCH_RST_TIME_MS 5
`define SOFT_RST_CYCLES (`SOFT_RST_TIME_US * `REF_CLK_MHZ)
`define GLITCH_RST_CYCLES (`GLITCH_RST_TIME_MS * 1000 * `REF_CLK_MHZ)

`endif

// File: rtl/mcu_clock_reset_output.v
// microcontroller clock output, clock tail and reset pin drive
// assumes crystal, low-frequency clock and shutdown arrive as pins; mode and
// interrupt flags come from logic on ref_clk_i
`timescale 1ns/1ps
`include "mcu_clock_consts.vh"

module mcu_clock_reset_output #(
  parameter SOFT_RST_CYCLES = `SOFT_RST_CYCLES,
  parameter GLITCH_RST_CYCLES = `GLITCH_RST_CYCLES
) (
  // clock and reset
  input wire ref_clk_i,
  input wire rst_b_i,
  // pins
  input wire xtal_clk_i,
  input wire lf_clk_i,
  input wire shutdown_pin_i,
  // mode and interrupt state
  input wire sleep_cmd_i,
  input wire irq_pending_i,
  input wire soft_rst_req_i,
  // register port
  input wire reg_wr_i,
  input wire [6:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  output reg [7:0] reg_rdata_o,
  // outputs
  output reg clock_out_pin_o,
  output reg xtal_en_o,
  output reg reset_out_o,
  output reg reset_out_b_o,
  output reg int_reset_o
);

  localparam ST_RUN = 2'h0;
  localparam ST_TAIL = 2'h1;
  localparam ST_STOP = 2'h2;

  // ==========================================
  // decode functions
  function [5:0] half_periods;
    input [2:0] sel;
    begin
      case (sel)
        3'h0: half_periods = `HP_30M;
        3'h1: half_periods = `HP_15M;
        3'h2: half_periods = `HP_10M;
        3'h3: half_periods = `HP_4M;
        3'h4: half_periods = `HP_3M;
        3'h5: half_periods = `HP_2M;
        3'h6: half_periods = `HP_1M;
        default: half_periods = `HP_1M;
      endcase
    end
  endfunction

  // tail length counts output periods, so it scales with the rate in use
  function [9:0] tail_len;
    input [1:0] t;
    begin
      case (t)
        2'h1: tail_len = `TAIL_128;
        2'h2: tail_len = `TAIL_256;
        2'h3: tail_len = `TAIL_512;
        default: tail_len = 10'h000;
      endcase
    end
  endfunction

  // ==========================================
  // pin synchronisers; third stage only feeds edge detection
  reg xtal_s1;
  reg xtal_s2;
  reg xtal_s3;
  reg lf_s1;
  reg lf_s2;
  reg lf_s3;
  reg shut_s1;
  reg shut_s2;

  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      xtal_s1 <= 1'b0;
      xtal_s2 <= 1'b0;
      xtal_s3 <= 1'b0;
      lf_s1 <= 1'b0;
      lf_s2 <= 1'b0;
      lf_s3 <= 1'b0;
      shut_s1 <= 1'b0;
      shut_s2 <= 1'b0;
    end else begin
      xtal_s1 <= xtal_clk_i;
      xtal_s2 <= xtal_s1;
      xtal_s3 <= xtal_s2;
      lf_s1 <= lf_clk_i;
      lf_s2 <= lf_s1;
      lf_s3 <= lf_s2;
      shut_s1 <= shutdown_pin_i;
      shut_s2 <= shut_s1;
    end
  end

  // both crystal edges count, so 4 MHz (7.5 crystal periods) stays exact
  wire xtal_edge = xtal_s2 ^ xtal_s3;
  wire lf_rise = lf_s2 & ~lf_s3;
  wire lf_fall = ~lf_s2 & lf_s3;

  // ==========================================
  // reset pulse generation
  // one counter serves both pulses; a soft request while it runs is dropped, not queued
  reg [19:0] rst_cnt;
  wire rst_act = (rst_cnt != 20'h0_0000) | shut_s2;

  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_cnt <= GLITCH_RST_CYCLES[19:0];
    end else if (shut_s2) begin
      rst_cnt <= GLITCH_RST_CYCLES[19:0];
    end else if (soft_rst_req_i && rst_cnt == 20'h0_0000) begin
      rst_cnt <= SOFT_RST_CYCLES[19:0];
    end else if (rst_cnt != 20'h0_0000) begin
      rst_cnt <= rst_cnt - 20'h0_0001;
    end
  end

  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      int_reset_o <= 1'b1;
      reset_out_o <= 1'b1;
      reset_out_b_o <= 1'b0;
    end else begin
      int_reset_o <= rst_act;
      reset_out_o <= rst_act;
      reset_out_b_o <= ~rst_act;
    end
  end

  // ==========================================
  // control register
  reg [7:0] ctrl;
  wire [2:0] freq_sel = ctrl[`MCO_FREQ_LSB +: 3];
  wire slow_en = ctrl[`MCO_SLOW_EN_BIT];
  wire [1:0] tail_sel = ctrl[`MCO_TAIL_LSB +: 2];
  wire addr_hit = (reg_addr_i == `MCO_CTRL_ADDR);

  // writes during any reset are dropped, so the defaults stand until it ends;
  // the two top bits are not stored and always read back zero
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl <= `MCO_CTRL_RESET;
    end else if (rst_act) begin
      ctrl <= `MCO_CTRL_RESET;
    end else if (reg_wr_i && addr_hit) begin
      ctrl <= reg_wdata_i & 8'h3f;
    end
  end

  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      reg_rdata_o <= addr_hit ? ctrl : 8'h00;
    end
  end

  // ==========================================
  // clock output state machine
  // sleep only counts once the interrupt is read
  wire sleep_eff = sleep_cmd_i & ~irq_pending_i;
  wire target_run = ~(sleep_eff & ~slow_en);
  wire target_lf = (sleep_eff & slow_en) | (freq_sel == `FREQ_SLOW);

  reg [1:0] st;
  reg src_lf;
  reg [5:0] cur_hp;
  reg [5:0] phase;
  reg [9:0] tcnt;

  wire [5:0] phase_inc = phase + 6'h01;
  wire [5:0] high_len = cur_hp - {1'b0, cur_hp[5:1]};
  wire div_end = xtal_edge & (phase_inc == cur_hp);
  // a boundary is where the output would next rise, so switching never cuts a pulse
  wire run_bnd = src_lf ? lf_rise : div_end;
  wire stop_bnd = target_lf ? lf_rise : xtal_edge;
  wire [9:0] tl = tail_len(tail_sel);

  reg [1:0] next_st;
  reg next_src_lf;
  reg [5:0] next_cur_hp;
  reg [5:0] next_phase;
  reg [9:0] next_tcnt;
  reg next_out;
  reg bnd;
  reg start;

  // ==========================================
  // next-state logic
  always @* begin
    next_st = st;
    next_src_lf = src_lf;
    next_cur_hp = cur_hp;
    next_phase = phase;
    next_tcnt = tcnt;
    next_out = clock_out_pin_o;
    bnd = (st == ST_STOP) ? stop_bnd : run_bnd;
    start = 1'b0;
    if (bnd) begin
      case (st)
        ST_RUN: begin
          if (!target_run) begin
            if (tl == 10'h000) begin
              next_st = ST_STOP;
            end else begin
              next_st = ST_TAIL;
              next_tcnt = tl - 10'h001;
              start = 1'b1;
            end
          end else begin
            next_src_lf = target_lf;
            next_cur_hp = half_periods(freq_sel);
            start = 1'b1;
          end
        end
        ST_TAIL: begin
          if (target_run) begin
            next_st = ST_RUN;
            next_src_lf = target_lf;
            next_cur_hp = half_periods(freq_sel);
            start = 1'b1;
          end else if (tcnt == 10'h000) begin
            next_st = ST_STOP;
          end else begin
            next_tcnt = tcnt - 10'h001;
            start = 1'b1;
          end
        end
        ST_STOP: begin
          if (target_run) begin
            next_st = ST_RUN;
            next_src_lf = target_lf;
            next_cur_hp = half_periods(freq_sel);
            start = 1'b1;
          end
        end
        default: begin
          next_st = ST_STOP;
        end
      endcase
      if (start) begin
        next_phase = 6'h00;
        next_out = 1'b1;
      end else begin
        next_out = 1'b0;
      end
    end else if (st != ST_STOP) begin
      if (src_lf) begin
        if (lf_fall) begin
          next_out = 1'b0;
        end
      end else if (xtal_edge) begin
        // divided clock: high for the first half, odd counts round high
        next_phase = phase_inc;
        next_out = (phase_inc < high_len);
      end
    end
  end

  // ==========================================
  // state registers
  // output starts low and waits for the first crystal edge after reset
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st <= ST_STOP;
      src_lf <= 1'b0;
      cur_hp <= `HP_1M;
      phase <= 6'h00;
      tcnt <= 10'h000;
      clock_out_pin_o <= 1'b0;
    end else begin
      st <= next_st;
      src_lf <= next_src_lf;
      cur_hp <= next_cur_hp;
      phase <= next_phase;
      tcnt <= next_tcnt;
      clock_out_pin_o <= next_out;
    end
  end

  // ==========================================
  // crystal enable: off only once sleep is effective and the crystal is unused
  // looking at the next state drops the crystal on the edge the output stops
  wire xtal_idle = (next_st == ST_STOP) || (next_st == ST_RUN && next_src_lf);

  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      xtal_en_o <= 1'b1;
    end else begin
      xtal_en_o <= ~(sleep_eff & xtal_idle);
    end
  end

endmodule

// File: dv/mcu_clock_monitor.sv
// ============================================
// port checker for the clock and reset output block
// assumes binding onto mcu_clock_reset_output, single ref_clk_i domain
`timescale 1ns/1ps
module mcu_clock_monitor #(
  parameter SOFT_RST_CYCLES = 20
) (
  input wire ref_clk_i,
  input wire rst_b_i,
  input wire irq_pending_i,
  input wire sleep_cmd_i,
  input wire [6:0] reg_addr_i,
  input wire [7:0] reg_rdata_o,
  input wire clock_out_pin_o,
  input wire xtal_en_o,
  input wire reset_out_o,
  input wire reset_out_b_o,
  input wire int_reset_o
);
  reg [15:0] rst_len;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  // length of the current internal reset pulse
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_len <= 16'h0000;
    end else begin
      rst_len <= int_reset_o ? rst_len + 16'h0001 : 16'h0000;
    end
  end
  reset_pair_a: assert property (reset_out_b_o == !reset_out_o) else $error("reset pins not inverse");
  reset_follow_a: assert property (reset_out_o == int_reset_o) else $error("reset pin not internal reset");
  soft_len_a: assert property ($fell(int_reset_o) |-> rst_len >= SOFT_RST_CYCLES - 1) else $error("reset short");
  ctrl_default_a: assert property ((int_reset_o && reg_addr_i == 7'h0a) [*3] |-> reg_rdata_o == 8'h06)
    else $error("ctrl not default in reset");
  rdata_zero_a: assert property (reg_addr_i != 7'h0a |=> reg_rdata_o == 8'h00) else $error("unmapped read");
  rdata_top_a: assert property (reg_rdata_o[7:6] == 2'b00) else $error("upper ctrl bits set");
  irq_hold_a: assert property (irq_pending_i && xtal_en_o |=> xtal_en_o) else $error("crystal off with irq");
  xtal_off_a: assert property ($fell(xtal_en_o) |-> $past(sleep_cmd_i) && !$past(irq_pending_i))
    else $error("crystal off outside sleep");
  cover property ($fell(xtal_en_o));
  cover property ($fell(int_reset_o));
  cover property ($rose(clock_out_pin_o));
endmodule

bind mcu_clock_reset_output mcu_clock_monitor #(.SOFT_RST_CYCLES(SOFT_RST_CYCLES)) i_mcu_clock_monitor (
  .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .irq_pending_i(irq_pending_i), .sleep_cmd_i(sleep_cmd_i),
  .reg_addr_i(reg_addr_i), .reg_rdata_o(reg_rdata_o), .clock_out_pin_o(clock_out_pin_o),
  .xtal_en_o(xtal_en_o), .reset_out_o(reset_out_o), .reset_out_b_o(reset_out_b_o), .int_reset_o(int_reset_o));

// File: dv/mcu_host_model.sv
// ============================================
// host model: counts clock rises, reads a pending interrupt after a few of them
// assumes its clock input is the registered output clock
`timescale 1ns/1ps
module mcu_host_model #(
  parameter READ_EDGES = 16
) (
  input wire ref_clk_i,
  input wire mcu_clk_i,
  input wire irq_set_i,
  input wire cnt_clr_i,
  output reg irq_pending_o = 1'b0,
  output reg [15:0] edges_o = 16'h0000
);
  reg last = 1'b0;
  reg [15:0] seen = 16'h0000;
  always @(posedge ref_clk_i) begin
    last <= mcu_clk_i;
    if (cnt_clr_i) begin
      edges_o <= 16'h0000;
    end else if (mcu_clk_i && !last) begin
      edges_o <= edges_o + 16'h0001;
    end
    // status read needs the host to run, so it only advances on clock rises
    if (irq_set_i) begin
      irq_pending_o <= 1'b1;
      seen <= 16'h0000;
    end else if (irq_pending_o && mcu_clk_i && !last) begin
      seen <= seen + 16'h0001;
      if (seen == READ_EDGES - 1) begin
        irq_pending_o <= 1'b0;
      end
    end
  end
endmodule

// File: dv/test_mcu_clock_reset_output.sv
// ============================================
// bench: register access, clock rates, sleep, tail and reset pulses
// assumes shortened reset counts of 20 and 50 cycles
`timescale 1ns/1ps
module test_mcu_clock_reset_output;
  reg ref_clk_i = 1'b0;
  reg rst_b_i = 1'b0;
  reg xtal_clk_i = 1'b0;
  reg lf_clk_i = 1'b0;
  reg shutdown_pin_i = 1'b0;
  reg sleep_cmd_i = 1'b0;
  reg soft_rst_req_i = 1'b0;
  reg reg_wr_i = 1'b0;
  reg [6:0] reg_addr_i = 7'h00;
  reg [7:0] reg_wdata_i = 8'h00;
  reg irq_set = 1'b0;
  reg cnt_clr = 1'b0;
  reg [55:0] fq = 56'h1e0f_0a04_0302_01;
  wire irq_pending_i;
  wire [15:0] edges;
  wire [7:0] reg_rdata_o;
  wire clock_out_pin_o, xtal_en_o, reset_out_o, reset_out_b_o, int_reset_o;
  integer fails = 0;
  integer checks = 0;
  integer cyc = 0;
  integer i;
  always #5 ref_clk_i = ~ref_clk_i;
  always #16.667 xtal_clk_i = ~xtal_clk_i;
  always #15258.8 lf_clk_i = ~lf_clk_i;
  mcu_clock_reset_output #(.SOFT_RST_CYCLES(20), .GLITCH_RST_CYCLES(50)) i_mcu_clock_reset_output (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .xtal_clk_i(xtal_clk_i), .lf_clk_i(lf_clk_i),
    .shutdown_pin_i(shutdown_pin_i), .sleep_cmd_i(sleep_cmd_i), .irq_pending_i(irq_pending_i),
    .soft_rst_req_i(soft_rst_req_i), .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .clock_out_pin_o(clock_out_pin_o), .xtal_en_o(xtal_en_o),
    .reset_out_o(reset_out_o), .reset_out_b_o(reset_out_b_o), .int_reset_o(int_reset_o));
  mcu_host_model #(.READ_EDGES(16)) i_mcu_host_model (.ref_clk_i(ref_clk_i), .mcu_clk_i(clock_out_pin_o),
    .irq_set_i(irq_set), .cnt_clr_i(cnt_clr), .irq_pending_o(irq_pending_i), .edges_o(edges));
  task summarize; begin
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  end endtask
  task cmp(input [7:0] got, input [7:0] exp); begin
    checks = checks + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  end endtask
  // counts come from sampled clocks, so a small slack is allowed
  task near(input [15:0] got, input [15:0] exp, input [15:0] tol); begin
    checks = checks + 1;
    if ((^got === 1'bx) || got > exp + tol || got + tol < exp) begin
      fails = fails + 1;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  end endtask
  task cyc_n(input integer n); begin
    repeat (n) @(negedge ref_clk_i);
  end endtask
  task wr(input [6:0] a, input [7:0] d); begin
    @(negedge ref_clk_i);
    reg_wr_i = 1'b1;
    reg_addr_i = a;
    reg_wdata_i = d;
    @(negedge ref_clk_i);
    reg_wr_i = 1'b0;
  end endtask
  task rd(input [6:0] a, input [7:0] e); begin
    @(negedge ref_clk_i);
    reg_addr_i = a;
    @(negedge ref_clk_i);
    cmp(reg_rdata_o, e);
  end endtask
  task clr; begin
    cnt_clr = 1'b1;
    cyc_n(1);
    cnt_clr = 1'b0;
  end endtask
  always @(posedge ref_clk_i) begin
    cyc = cyc + 1;
    if (cyc == 60000) begin
      fails = fails + 1;
      summarize;
    end
  end
  initial begin
    cyc_n(4);
    rst_b_i = 1'b1;
    rd(7'h0a, 8'h06);
    rd(7'h05, 8'h00);
    cmp({7'h00, reset_out_o}, 8'h01);
    cmp({7'h00, reset_out_b_o}, 8'h00);
    cyc_n(60);
    cmp({7'h00, reset_out_o}, 8'h00);
    cmp({7'h00, reset_out_b_o}, 8'h01);
    for (i = 0; i < 7; i = i + 1) begin
      wr(7'h0a, i[7:0]);
      cyc_n(300);
      clr;
      cyc_n(1500);
      near(edges, 16'h000f * fq[8 * (6 - i) +: 8], 16'h0002);
    end
    wr(7'h0a, 8'h07);
    cyc_n(200);
    clr;
    cyc_n(9156);
    near(edges, 16'h0003, 16'h0001);
    cmp({7'h00, xtal_en_o}, 8'h01);
    wr(7'h0a, 8'h08);
    sleep_cmd_i = 1'b1;
    cyc_n(200);
    clr;
    cyc_n(9156);
    near(edges, 16'h0003, 16'h0001);
    cmp({7'h00, xtal_en_o}, 8'h00);
    sleep_cmd_i = 1'b0;
    cyc_n(3500);
    for (i = 0; i < 4; i = i + 1) begin
      wr(7'h0a, {2'b00, i[1:0], 4'h0});
      cyc_n(100);
      irq_set = 1'b1;
      cnt_clr = 1'b1;
      cyc_n(1);
      irq_set = 1'b0;
      cnt_clr = 1'b0;
      sleep_cmd_i = 1'b1;
      cyc_n(2500);
      near(edges, 16'h0010 + ((i == 0) ? 16'h0000 : (16'h0040 << i)), 16'h0003);
      cmp({7'h00, xtal_en_o}, 8'h00);
      cmp({7'h00, clock_out_pin_o}, 8'h00);
      sleep_cmd_i = 1'b0;
      cyc_n(100);
    end
    wr(7'h0a, 8'h01);
    shutdown_pin_i = 1'b1;
    cyc_n(20);
    shutdown_pin_i = 1'b0;
    cyc_n(30);
    cmp({7'h00, int_reset_o}, 8'h01);
    cyc_n(40);
    cmp({7'h00, int_reset_o}, 8'h00);
    rd(7'h0a, 8'h06);
    wr(7'h0a, 8'h01);
    soft_rst_req_i = 1'b1;
    cyc_n(1);
    soft_rst_req_i = 1'b0;
    cyc_n(10);
    cmp({7'h00, int_reset_o}, 8'h01);
    cyc_n(20);
    cmp({7'h00, int_reset_o}, 8'h00);
    rd(7'h0a, 8'h06);
    wr(7'h0a, 8'hff);
    rd(7'h0a, 8'h3f);
    wr(7'h7f, 8'h3f);
    rd(7'h7f, 8'h00);
    summarize;
  end
endmodule
